/* File: hw/dcd_cfg.svh */
`ifndef DCD_CFG_SVH
`define DCD_CFG_SVH
// -----------------------------------------------------------------
// Link widths and mode register fields
// -----------------------------------------------------------------
`define DCD_ADDR_W 20
`define DCD_BANK_W 4
`define DCD_NBANK 16
`define DCD_MR_NUM 3
`define DCD_MR_RST 20'h00000
`define DCD_MR0_BL_LSB 0
`define DCD_MONE_REF_MULTI 8
`define DCD_MTWO_WR_LSB 3
`define DCD_BL_CODE_MAX 2'h2
// -----------------------------------------------------------------
// Controller register offsets and fields
// -----------------------------------------------------------------
`define DCD_REG_CMD 6'h00
`define DCD_REG_ADDR 6'h04
`define DCD_REG_BANK 6'h08
`define DCD_REG_WDATA 6'h0C
`define DCD_REG_WMASK 6'h10
`define DCD_REG_BLEN 6'h14
`define DCD_REG_STATUS 6'h18
`define DCD_CMD_DIE_LSB 4
`define DCD_ST_BUSY 0
`define DCD_ST_REFUSED 1
`define DCD_RESP_OK 2'h0
`define DCD_RESP_ERR 2'h2
`endif

/* File: hw/dcd_pkg.sv */
package dcd_pkg;
  typedef enum logic [2:0] {
    DCD_NOP = 3'h0,
    DCD_MSET = 3'h1,
    DCD_READ = 3'h2,
    DCD_WRITE = 3'h3,
    DCD_REFR = 3'h4
  } dcd_cmd_t;
  typedef enum logic [1:0] {
    DCD_D_IDLE = 2'h1,
    DCD_D_BURST = 2'h2
  } dcd_dev_st_t;
  typedef enum logic [2:0] {
    DCD_H_IDLE = 3'h1,
    DCD_H_ISSUE = 3'h2,
    DCD_H_BURST = 3'h4
  } dcd_host_st_t;
endpackage

/* File: hw/dcd_link_if.sv */
`timescale 1ns/1ps
`include "dcd_cfg.svh"
interface dcd_link_if #(
  parameter int DATA_W = 18
);
  logic die0_select_n;
  logic die1_select_n;
  logic write_en_n;
  logic refresh_n;
  logic [`DCD_ADDR_W-1:0] addr;
  logic [`DCD_BANK_W-1:0] bank;
  logic [DATA_W-1:0] data;
  logic data_mask;
  modport host (
    output die0_select_n, die1_select_n, write_en_n, refresh_n, addr, bank, data, data_mask
  );
  modport dev (
    input die0_select_n, die1_select_n, write_en_n, refresh_n, addr, bank, data, data_mask
  );
endinterface

/* File: hw/dcd_device_end.sv */
`timescale 1ns/1ps
`include "dcd_cfg.svh"
// Functional notes
// (RQ1) Sample command and address on rising edge.
// (RQ2) No-op starts nothing, bursts continue.
// (RQ3) Mode registers hold until rewrite or reset.
// (RQ4) Mode set only when banks idle.
// (RQ5) Read targets selected bank and address.
// (RQ6) Mode two bits 4:3 pick write banks.
// (RQ7) Write uses bank bits 3, 2, 1 down.
// (RQ8) Masked-low beats stored, masked-high dropped.
// (RQ9) Refresh: single bank or multi-bank method.
// (RQ10) Every refresh needs its own command.
// (RQ11) Wide configuration command level decode.
// (RQ12) Two-rank decode with per-die targeting.
// (RQ13) Both selects low only for set/refresh.
// (RQ14) Mode value taken from address and bank.
// (RQ15) Refresh ignores the unused input group.
// (RQ16) Used address bits follow burst, configuration.
// (RQ17) Multi-bank refresh: low address flags banks.
// (RQ18) Mode one bit 8 picks refresh method.
// (RQ19) Unlisted level combinations act as no-op.
module dcd_device_end import dcd_pkg::*; #(
  parameter int TWO_RANK = 1,
  parameter int DATA_W = 18
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  // Command and data link
  dcd_link_if.dev LINK,
  // Decoded operations
  output logic O_RD_PULSE,
  output logic O_WR_PULSE,
  output logic O_REF_PULSE,
  output logic O_MSET_PULSE,
  output logic [1:0] O_DIE,
  output logic [`DCD_NBANK-1:0] O_BANKS,
  output logic [`DCD_ADDR_W-1:0] O_ADDR,
  // Write data
  output logic O_WR_BEAT,
  output logic O_WR_STORE,
  output logic [DATA_W-1:0] O_WR_DATA,
  // Mode register contents, die 1 above die 0
  output logic [2*`DCD_MR_NUM*`DCD_ADDR_W-1:0] O_MODE
);
  initial begin
    if (TWO_RANK != 0 && TWO_RANK != 1) $error("TWO_RANK must be 0 or 1");
    if (DATA_W < 1) $error("DATA_W must be positive");
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [1:0] sel;
  logic [1:0] lvl;
  dcd_cmd_t cmd;
  assign sel = (TWO_RANK != 0) ? {~LINK.die1_select_n, ~LINK.die0_select_n} : {1'b0, ~LINK.die0_select_n};
  assign lvl = {LINK.write_en_n, LINK.refresh_n};

  always_comb begin
    cmd = DCD_NOP;
    if (sel != 2'h0) begin
      case (lvl)
        2'h0: cmd = DCD_MSET; // RQ11 RQ12
        2'h2: cmd = DCD_REFR; // RQ11 RQ12
        2'h1: cmd = (sel == 2'h3) ? DCD_NOP : DCD_WRITE; // RQ13 RQ19
        2'h3: cmd = (sel == 2'h3) ? DCD_NOP : DCD_READ; // RQ13 RQ19
        default: cmd = DCD_NOP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mode registers
  // ---------------------------------------------------------------
  logic [`DCD_ADDR_W-1:0] mode_ff [2][`DCD_MR_NUM];

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int d = 0; d < 2; d++) begin
        for (int r = 0; r < `DCD_MR_NUM; r++) begin
          mode_ff[d][r] <= `DCD_MR_RST; // RQ3
        end
      end
    end else if (cmd == DCD_MSET && LINK.bank[1:0] != 2'h3) begin
      // Bank bits 1:0 pick the register, the address carries its value.
      for (int d = 0; d < 2; d++) begin
        if (sel[d]) begin
          mode_ff[d][LINK.bank[1:0]] <= LINK.addr; // RQ14 RQ13 RQ4
        end
      end
    end
  end

  // The lower die of the target set supplies the mode bits.
  logic die_ix;
  logic [`DCD_ADDR_W-1:0] mr0;
  logic [`DCD_ADDR_W-1:0] mone;
  logic [`DCD_ADDR_W-1:0] mtwo;
  logic [1:0] bl_code;
  assign die_ix = ~sel[0];
  assign mr0 = mode_ff[die_ix][0];
  assign mone = mode_ff[die_ix][1];
  assign mtwo = mode_ff[die_ix][2];
  assign bl_code = (mr0[`DCD_MR0_BL_LSB+:2] > `DCD_BL_CODE_MAX) ? `DCD_BL_CODE_MAX : mr0[`DCD_MR0_BL_LSB+:2];

  // ---------------------------------------------------------------
  // Bank and address selection
  // ---------------------------------------------------------------
  logic [`DCD_NBANK-1:0] nxt_banks;
  logic [`DCD_ADDR_W-1:0] addr_keep;
  logic [4:0] drop;

  always_comb begin
    nxt_banks = '0;
    case (cmd)
      DCD_READ: nxt_banks[LINK.bank] = 1'b1; // RQ5
      DCD_WRITE: begin
        case (mtwo[`DCD_MTWO_WR_LSB+:2]) // RQ6
          2'h1: begin
            nxt_banks[{1'b0, LINK.bank[2:0]}] = 1'b1; // RQ7
            nxt_banks[{1'b1, LINK.bank[2:0]}] = 1'b1; // RQ7
          end
          2'h2: begin
            for (int q = 0; q < 4; q++) begin
              nxt_banks[{q[1:0], LINK.bank[1:0]}] = 1'b1; // RQ7
            end
          end
          default: nxt_banks[LINK.bank] = 1'b1; // RQ7
        endcase
      end
      DCD_REFR: begin
        if (mone[`DCD_MONE_REF_MULTI]) begin // RQ18 RQ9
          nxt_banks = LINK.addr[`DCD_NBANK-1:0]; // RQ17 RQ15
        end else begin
          nxt_banks[LINK.bank] = 1'b1; // RQ15
        end
      end
      default: nxt_banks = '0;
    endcase
  end

  // Longer bursts and the wide part need fewer column bits.
  assign drop = {3'h0, bl_code} + ((TWO_RANK != 0) ? 5'h00 : 5'h01);
  assign addr_keep = LINK.addr & ({`DCD_ADDR_W{1'b1}} >> drop); // RQ16

  // ---------------------------------------------------------------
  // Operation outputs
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RD_PULSE <= 1'b0;
      O_WR_PULSE <= 1'b0;
      O_REF_PULSE <= 1'b0;
      O_MSET_PULSE <= 1'b0;
      O_DIE <= 2'h0;
      O_BANKS <= '0;
      O_ADDR <= '0;
    end else begin
      // Each refresh command yields exactly one refresh pulse.
      O_RD_PULSE <= (cmd == DCD_READ); // RQ1 RQ10
      O_WR_PULSE <= (cmd == DCD_WRITE);
      O_REF_PULSE <= (cmd == DCD_REFR); // RQ10
      O_MSET_PULSE <= (cmd == DCD_MSET);
      if (cmd != DCD_NOP) begin // RQ2 RQ19
        O_DIE <= sel;
        O_BANKS <= nxt_banks;
        O_ADDR <= (cmd == DCD_READ || cmd == DCD_WRITE) ? addr_keep : '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Write burst
  // ---------------------------------------------------------------
  dcd_dev_st_t st_ff;
  logic [3:0] left_ff;
  logic [3:0] nxt_left;
  assign nxt_left = 4'h2 << bl_code;

  // A new write restarts the count; the controller must not overlap bursts.
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_ff <= DCD_D_IDLE;
      left_ff <= 4'h0;
    end else if (cmd == DCD_WRITE) begin
      st_ff <= DCD_D_BURST;
      left_ff <= nxt_left;
    end else begin
      case (st_ff)
        DCD_D_BURST: begin
          left_ff <= left_ff - 4'h1; // RQ2
          if (left_ff == 4'h1) begin
            st_ff <= DCD_D_IDLE;
          end
        end
        default: st_ff <= DCD_D_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WR_BEAT <= 1'b0;
      O_WR_STORE <= 1'b0;
      O_WR_DATA <= '0;
    end else begin
      O_WR_BEAT <= (st_ff == DCD_D_BURST);
      O_WR_STORE <= (st_ff == DCD_D_BURST) && !LINK.data_mask; // RQ8
      if (st_ff == DCD_D_BURST && !LINK.data_mask) begin
        O_WR_DATA <= LINK.data; // RQ8
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode register view
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_MODE <= '0;
    end else begin
      for (int d = 0; d < 2; d++) begin
        for (int r = 0; r < `DCD_MR_NUM; r++) begin
          O_MODE[(d*`DCD_MR_NUM+r)*`DCD_ADDR_W+:`DCD_ADDR_W] <= mode_ff[d][r];
        end
      end
    end
  end
endmodule

/* File: hw/dcd_host_end.sv */
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_host_end import dcd_pkg::*; #(
  parameter int TWO_RANK = 1,
  parameter int DATA_W = 18
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  // AXI4-Lite write channels
  input wire logic [5:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // AXI4-Lite read channels
  input wire logic [5:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // Command and data link
  dcd_link_if.host LINK
);
  initial begin
    if (TWO_RANK != 0 && TWO_RANK != 1) $error("TWO_RANK must be 0 or 1");
    if (DATA_W < 1 || DATA_W > 32) $error("DATA_W must be 1 to 32");
  end

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic aw_got_ff;
  logic w_got_ff;
  logic [5:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_fire;
  logic wr_map;
  assign wr_fire = aw_got_ff && w_got_ff && !O_BVALID;
  assign wr_map = (awaddr_ff[1:0] == 2'h0) && (awaddr_ff <= `DCD_REG_STATUS);

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `DCD_RESP_OK;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 6'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_got_ff <= 1'b1;
        O_AWREADY <= 1'b0;
        awaddr_ff <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_got_ff <= 1'b1;
        O_WREADY <= 1'b0;
        wdata_ff <= I_WDATA;
        wstrb_ff <= I_WSTRB;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= wr_map ? `DCD_RESP_OK : `DCD_RESP_ERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [31:0] bmask;
  logic [5:0] cmd_ff;
  logic [`DCD_ADDR_W-1:0] addr_ff;
  logic [`DCD_BANK_W-1:0] bank_ff;
  logic [DATA_W-1:0] wd_ff;
  logic [7:0] wmask_ff;
  logic [1:0] blen_ff;
  logic refused_ff;
  logic busy;
  logic go;
  logic [31:0] mrg;
  dcd_host_st_t st_ff;
  assign bmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign busy = (st_ff != DCD_H_IDLE);
  assign go = wr_fire && awaddr_ff == `DCD_REG_CMD && wstrb_ff[0] && !busy; // RQ4 RQ10

  always_comb begin
    mrg = 32'h00000000;
    case (awaddr_ff)
      `DCD_REG_CMD: mrg = {26'h0, cmd_ff};
      `DCD_REG_ADDR: mrg = {12'h0, addr_ff};
      `DCD_REG_BANK: mrg = {28'h0, bank_ff};
      `DCD_REG_WDATA: mrg = 32'(wd_ff);
      `DCD_REG_WMASK: mrg = {24'h0, wmask_ff};
      `DCD_REG_BLEN: mrg = {30'h0, blen_ff};
      default: mrg = 32'h00000000;
    endcase
    mrg = (mrg & ~bmask) | (wdata_ff & bmask);
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      cmd_ff <= 6'h00;
      addr_ff <= '0;
      bank_ff <= '0;
      wd_ff <= '0;
      wmask_ff <= 8'h00;
      blen_ff <= 2'h0;
      refused_ff <= 1'b0;
    end else begin
      if (wr_fire) begin
        case (awaddr_ff)
          `DCD_REG_CMD: cmd_ff <= busy ? cmd_ff : mrg[5:0];
          `DCD_REG_ADDR: addr_ff <= mrg[`DCD_ADDR_W-1:0];
          `DCD_REG_BANK: bank_ff <= mrg[`DCD_BANK_W-1:0];
          `DCD_REG_WDATA: wd_ff <= mrg[DATA_W-1:0];
          `DCD_REG_WMASK: wmask_ff <= mrg[7:0];
          `DCD_REG_BLEN: blen_ff <= (mrg[1:0] > `DCD_BL_CODE_MAX) ? `DCD_BL_CODE_MAX : mrg[1:0];
          `DCD_REG_STATUS: refused_ff <= refused_ff & ~(wstrb_ff[0] & wdata_ff[`DCD_ST_REFUSED]);
          default: refused_ff <= refused_ff;
        endcase
      end
      // A refusal in the same cycle as its clear is kept.
      if (wr_fire && awaddr_ff == `DCD_REG_CMD && busy) begin
        refused_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= `DCD_RESP_OK;
    end else if (I_ARVALID && O_ARREADY) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b1;
      O_RRESP <= `DCD_RESP_OK;
      case (I_ARADDR)
        `DCD_REG_CMD: O_RDATA <= {26'h0, cmd_ff};
        `DCD_REG_ADDR: O_RDATA <= {12'h0, addr_ff};
        `DCD_REG_BANK: O_RDATA <= {28'h0, bank_ff};
        `DCD_REG_WDATA: O_RDATA <= 32'(wd_ff);
        `DCD_REG_WMASK: O_RDATA <= {24'h0, wmask_ff};
        `DCD_REG_BLEN: O_RDATA <= {30'h0, blen_ff};
        `DCD_REG_STATUS: O_RDATA <= {30'h0, refused_ff, busy};
        default: begin
          O_RDATA <= 32'h00000000;
          O_RRESP <= `DCD_RESP_ERR;
        end
      endcase
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Link sequencer
  // ---------------------------------------------------------------
  logic [3:0] beat_ff;
  logic [1:0] die;
  logic [2:0] code;
  assign code = cmd_ff[2:0];
  assign die = (TWO_RANK != 0) ? cmd_ff[`DCD_CMD_DIE_LSB+:2] : 2'h1;

  // Idle levels differ by configuration, so the controller drives them here.
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_ff <= DCD_H_IDLE;
      beat_ff <= 4'h0;
      LINK.die0_select_n <= 1'b1;
      LINK.die1_select_n <= 1'b1;
      LINK.write_en_n <= 1'b1;
      LINK.refresh_n <= (TWO_RANK == 0);
      LINK.addr <= '0;
      LINK.bank <= '0;
      LINK.data <= '0;
      LINK.data_mask <= 1'b1;
    end else begin
      LINK.die0_select_n <= 1'b1;
      LINK.die1_select_n <= 1'b1;
      LINK.write_en_n <= 1'b1;
      LINK.refresh_n <= (TWO_RANK == 0);
      LINK.data_mask <= 1'b1;
      case (st_ff)
        DCD_H_IDLE: if (go) st_ff <= DCD_H_ISSUE;
        DCD_H_ISSUE: begin
          st_ff <= DCD_H_IDLE;
          if (code == DCD_MSET || code == DCD_READ || code == DCD_WRITE || code == DCD_REFR) begin
            LINK.die0_select_n <= ~die[0];
            LINK.die1_select_n <= ~die[1];
            LINK.write_en_n <= !(code == DCD_MSET || code == DCD_WRITE);
            LINK.refresh_n <= !(code == DCD_MSET || code == DCD_REFR);
            LINK.addr <= addr_ff;
            LINK.bank <= bank_ff;
          end
          if (code == DCD_WRITE) begin
            st_ff <= DCD_H_BURST;
            beat_ff <= 4'h0;
          end
        end
        DCD_H_BURST: begin
          LINK.data <= wd_ff;
          LINK.data_mask <= wmask_ff[beat_ff[2:0]];
          beat_ff <= beat_ff + 4'h1;
          if (beat_ff == (4'h2 << blen_ff) - 4'h1) st_ff <= DCD_H_IDLE;
        end
        default: st_ff <= DCD_H_IDLE;
      endcase
    end
  end
endmodule

/* File: testbench/dcd_link_assertions.sv */
`timescale 1ns/1ps
module dcd_link_assertions #(
  parameter int DATA_W = 18
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  // Link signals
  input wire logic die0_select_n,
  input wire logic die1_select_n,
  input wire logic write_en_n,
  input wire logic refresh_n,
  input wire logic [19:0] addr,
  input wire logic [3:0] bank,
  input wire logic [DATA_W-1:0] data,
  input wire logic data_mask,
  // Device outputs
  input wire logic O_RD_PULSE,
  input wire logic O_WR_PULSE,
  input wire logic O_REF_PULSE,
  input wire logic O_MSET_PULSE,
  input wire logic [1:0] O_DIE,
  input wire logic [15:0] O_BANKS,
  input wire logic O_WR_BEAT,
  input wire logic O_WR_STORE,
  input wire logic [DATA_W-1:0] O_WR_DATA,
  input wire logic [119:0] O_MODE
);
  // ----------------------------------------
  // Expected targets from the lower selected die
  // ----------------------------------------
  wire [1:0] wr_code = die0_select_n ? O_MODE[104:103] : O_MODE[44:43];
  wire ref_multi = die0_select_n ? O_MODE[88] : O_MODE[28];
  wire [15:0] one_hot = 16'h1 << bank;
  wire [15:0] wr_set = (wr_code == 2'h1) ? ((16'h1 << bank[2:0]) | (16'h100 << bank[2:0])) :
                       (wr_code == 2'h2) ? (16'h1111 << bank[1:0]) : one_hot;
  wire [15:0] ref_set = ref_multi ? addr[15:0] : one_hot;
  wire one_die = die0_select_n ^ die1_select_n;
  wire any_die = !(die0_select_n && die1_select_n);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);
  sequence s_read;
    one_die && write_en_n && refresh_n;
  endsequence
  sequence s_write;
    one_die && !write_en_n && refresh_n;
  endsequence
  sequence s_refr;
    any_die && write_en_n && !refresh_n;
  endsequence
  sequence s_mset;
    any_die && !write_en_n && !refresh_n && bank[1:0] != 2'h3;
  endsequence
  // ----------------------------------------
  // Decode and targeting
  // ----------------------------------------
  a_read_target: assert property (s_read |=> O_RD_PULSE && O_BANKS == (16'h1 << $past(bank)) &&
    O_DIE == {~$past(die1_select_n), ~$past(die0_select_n)}) else $error("read decode or target wrong");
  a_write_burst: assert property (s_write |=> O_WR_PULSE ##1 O_WR_BEAT) else $error("write burst not started");
  a_write_banks: assert property (s_write |=> O_BANKS == $past(wr_set)) else $error("write bank set wrong");
  a_refresh_banks: assert property (s_refr |=> O_REF_PULSE && O_BANKS == $past(ref_set))
    else $error("refresh bank set wrong");
  a_mode_decode: assert property (s_mset |=> O_MSET_PULSE) else $error("mode set not decoded");
  a_mode_hold: assert property ($changed(O_MODE) |-> $past(O_MSET_PULSE)) else $error("stray mode change");
  a_nop_quiet: assert property (!any_die |=> !O_RD_PULSE && !O_WR_PULSE && !O_REF_PULSE && !O_MSET_PULSE)
    else $error("operation on deselected link");
  a_both_no_rw: assert property (!die0_select_n && !die1_select_n && refresh_n |=> !O_RD_PULSE && !O_WR_PULSE)
    else $error("access to both dies accepted");
  // Beats are judged against the link one cycle earlier.
  a_beat_mask: assert property (O_WR_BEAT |-> O_WR_STORE == !$past(data_mask)) else $error("mask gating wrong");
  a_store_data: assert property (O_WR_STORE |-> O_WR_DATA == $past(data)) else $error("stored beat wrong");
endmodule

/* File: testbench/tb_dram_command_decode.sv */
`timescale 1ns/1ps
module tb_dram_command_decode import dcd_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [5:0] awaddr = 6'h0, araddr = 6'h0;
  logic [31:0] wdata = 32'h0, rdata, rnd = 32'hD302;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rd_p, wr_p, ref_p, mset_p, beat, store;
  logic [1:0] bresp, rresp, die_o, r;
  logic [15:0] banks;
  logic [19:0] addr_o;
  logic [17:0] wd_o;
  logic [119:0] mode_o;
  int fails = 0, n_checks = 0, n_rd = 0, n_wr = 0, n_ref = 0, n_mset = 0, n_beat = 0, n_st = 0;
  int mode[2][4];
  always #5 clk = ~clk;
  dcd_link_if #(.DATA_W(18)) link();
  dcd_host_end u_dcd_host_end (.I_CLOCK(clk), .I_NRST(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .LINK(link));
  dcd_device_end u_dcd_device_end (.I_CLOCK(clk), .I_NRST(rst_n), .LINK(link), .O_RD_PULSE(rd_p),
    .O_WR_PULSE(wr_p), .O_REF_PULSE(ref_p), .O_MSET_PULSE(mset_p), .O_DIE(die_o), .O_BANKS(banks),
    .O_ADDR(addr_o), .O_WR_BEAT(beat), .O_WR_STORE(store), .O_WR_DATA(wd_o), .O_MODE(mode_o));
  dcd_link_assertions u_dcd_link_assertions (.I_CLOCK(clk), .I_NRST(rst_n), .die0_select_n(link.die0_select_n),
    .die1_select_n(link.die1_select_n), .write_en_n(link.write_en_n), .refresh_n(link.refresh_n),
    .addr(link.addr), .bank(link.bank), .data(link.data), .data_mask(link.data_mask), .O_RD_PULSE(rd_p),
    .O_WR_PULSE(wr_p), .O_REF_PULSE(ref_p), .O_MSET_PULSE(mset_p), .O_DIE(die_o), .O_BANKS(banks),
    .O_WR_BEAT(beat), .O_WR_STORE(store), .O_WR_DATA(wd_o), .O_MODE(mode_o));
  // ----------------------------------------
  // Pulse counters, compared as deltas
  // ----------------------------------------
  always @(posedge clk) begin
    n_rd += (rd_p === 1'b1);
    n_wr += (wr_p === 1'b1);
    n_ref += (ref_p === 1'b1);
    n_mset += (mset_p === 1'b1);
    n_beat += (beat === 1'b1);
    n_st += (store === 1'b1);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction
  task automatic check(input logic [119:0] seen, input logic [119:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang;
    fails++;
    $display("BAD %0t wait ran out", $time);
    tally_and_finish();
  endtask
  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] resp);
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (k == 100) hang();
  endtask
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (k == 100) hang();
  endtask
  // Issues one command and returns the pulse deltas packed as rd + 4*wr + 16*ref + 64*mrs.
  task automatic cmd(input int code, input int die, output int got);
    int s, k;
    logic [31:0] st;
    s = n_rd + 4 * n_wr + 16 * n_ref + 64 * n_mset;
    axi_wr(6'h00, {26'h0, die[1:0], 1'b0, code[2:0]}, r);
    for (k = 0; k < 50; k++) begin
      axi_rd(6'h18, st, r);
      if (st[0] === 1'b0) break;
    end
    if (k == 50) hang();
    repeat (2) @(posedge clk);
    got = n_rd + 4 * n_wr + 16 * n_ref + 64 * n_mset - s;
  endtask
  task automatic mset(input int die, input int reg_i, input logic [19:0] v);
    int got;
    axi_wr(6'h04, {12'h0, v}, r);
    axi_wr(6'h08, reg_i, r);
    cmd(1, die, got);
    check(got, 64);
    for (int d = 0; d < 2; d++) begin
      if (die[d] && reg_i < 3) mode[d][reg_i] = v;
    end
    for (int i = 0; i < 6; i++) check(mode_o[i*20 +: 20], mode[i/3][i%3]);
  endtask
  initial begin
    int got, bl, st_0;
    logic [31:0] d, msk;
    logic [15:0] exp_b;
    for (int i = 0; i < 8; i++) mode[i/4][i%4] = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Register defaults and an unmapped address.
    axi_rd(6'h18, d, r);
    check({d, r}, 34'h0);
    axi_rd(6'h1C, d, r);
    check({d, r}, {32'h0, 2'h2});
    axi_wr(6'h1C, 32'h1, r);
    check(r, 2'h2);
    wstrb <= 4'h2;
    axi_wr(6'h04, 32'hFFFFF, r);
    wstrb <= 4'hF;
    axi_rd(6'h04, d, r);
    check(d, 32'hFF00);
    $display("registers done");
    // Mode set to each die and register; register index 3 is ignored.
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      mset(i / 4 + 1, i % 4, rnd[19:0] & 20'hFFEFC);
    end
    $display("mode set done");
    // Reads per burst code trim upper address bits.
    for (int i = 0; i < 6; i++) begin
      bl = i / 2;
      mset(3, 0, bl);
      axi_wr(6'h14, bl, r);
      rnd = lfsr(rnd);
      axi_wr(6'h04, rnd[19:0], r);
      axi_wr(6'h08, rnd[23:20], r);
      cmd(2, i % 2 + 1, got);
      check(got, 1);
      check({die_o, banks}, {2'(i % 2 + 1), 16'h1 << rnd[23:20]});
      check(addr_o, rnd[19:0] & ((20'h1 << (20 - bl)) - 20'h1));
    end
    $display("read done");
    // Writes in each bank mode with a random beat mask; burst of 8.
    for (int wc = 0; wc < 4; wc++) begin
      mset(3, 2, wc << 3);
      rnd = lfsr(rnd);
      msk = lfsr(rnd);
      axi_wr(6'h08, rnd[3:0], r);
      axi_wr(6'h0C, rnd, r);
      axi_wr(6'h10, msk[7:0], r);
      exp_b = (wc == 1) ? ((16'h1 << rnd[2:0]) | (16'h100 << rnd[2:0])) :
              (wc == 2) ? (16'h1111 << rnd[1:0]) : (16'h1 << rnd[3:0]);
      st_0 = n_st;
      bl = n_beat;
      cmd(3, 2, got);
      check(got, 4);
      check(banks, exp_b);
      check({n_beat - bl, n_st - st_0}, {32'd8, 32'(8 - $countones(msk[7:0]))});
      if (msk[7:0] != 8'hFF) check(wd_o, rnd[17:0]);
    end
    $display("write done");
    // Refresh in both methods to each die set.
    for (int i = 0; i < 6; i++) begin
      if (i % 3 == 0) mset(3, 1, (i / 3) << 8);
      rnd = lfsr(rnd);
      axi_wr(6'h04, rnd[19:0], r);
      axi_wr(6'h08, rnd[23:20], r);
      cmd(4, i % 3 + 1, got);
      check(got, 16);
      check({die_o, banks}, {2'(i % 3 + 1), (i < 3) ? (16'h1 << rnd[23:20]) : rnd[15:0]});
    end
    $display("refresh done");
    // Both dies for access, and unlisted codes, do nothing.
    cmd(2, 3, got);
    check(got, 0);
    cmd(3, 3, got);
    check(got, 0);
    for (int c = 5; c < 9; c++) begin
      cmd(c % 8, 1, got);
      check(got, 0);
    end
    $display("refusal done");
    // A command while a burst runs is dropped and flagged.
    axi_wr(6'h00, 32'h13, r);
    cmd(2, 1, got);
    check(got, 4);
    axi_rd(6'h18, d, r);
    check(d[1:0], 2'h2);
    axi_wr(6'h18, 32'h2, r);
    axi_rd(6'h18, d, r);
    check(d[1:0], 2'h0);
    $display("busy done");
    tally_and_finish();
  end
endmodule
